// File: rtl/dmc_pkg.sv
package dmc_pkg;
    // ****************************************
    // Word and packet layout
    // ****************************************
    localparam int          WORD_W        = 16;
    localparam int          ADDR_W        = 15;
    localparam int          DEV_W         = 6;
    localparam int          PKT_WORDS     = 4;
    localparam logic [1:0]  PKT_FUNC      = 2'h0;
    localparam logic [1:0]  PKT_FINAL     = 2'h1;
    localparam logic [1:0]  PKT_START     = 2'h2;
    localparam logic [ADDR_W-1:0] PKT_BASE = 15'h0010;
    localparam logic [1:0]  IRQ_CHANNEL   = 2'h2;
    // Function word fields
    localparam int          FN_DIR_BIT    = 15;
    localparam int          FN_PROTIRQ_BIT = 14;
    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_PERIOD_PS = 10000;
    localparam int          MEM_CYCLE_PS  = 1650000;
    localparam int          MEM_CYCLE_CLKS = MEM_CYCLE_PS / CLK_PERIOD_PS;
    localparam int          MAX_RATE_WPS  = 600000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PKT    = 3'b001,
        ST_WAIT   = 3'b010,
        ST_STEAL  = 3'b011,
        ST_ADV    = 3'b100
    } dmc_state_t;

    function automatic logic odd_parity(input logic [WORD_W-1:0] w);
        odd_parity = ~(^w);
    endfunction : odd_parity
endpackage : dmc_pkg

// File: rtl/dmc_link_if.sv
`timescale 1ns/10ps
interface dmc_link_if;
    logic [15:0] to_dev_data;
    logic        to_dev_par;
    logic        to_dev_valid;
    logic        to_dev_ready;
    logic [15:0] from_dev_data;
    logic        from_dev_par;
    logic        from_dev_valid;
    logic        from_dev_ready;
    logic [15:0] func_word;
    logic        func_valid;
    logic [5:0]  dev_sel;
    logic        dir_in;
    logic        active;
    logic        par_inhibit;
    logic        dev_irq;
    logic        irq_ack;
    logic [5:0]  ack_addr;
    logic        ack_addr_valid;

    modport chan (
        output to_dev_data, to_dev_par, to_dev_valid, func_word, func_valid, dev_sel, dir_in, active,
               irq_ack, from_dev_ready,
        input  to_dev_ready, from_dev_data, from_dev_par, from_dev_valid, par_inhibit, dev_irq,
               ack_addr, ack_addr_valid
    );
    modport dev (
        input  to_dev_data, to_dev_par, to_dev_valid, func_word, func_valid, dev_sel, dir_in, active,
               irq_ack, from_dev_ready,
        output to_dev_ready, from_dev_data, from_dev_par, from_dev_valid, par_inhibit, dev_irq,
               ack_addr, ack_addr_valid
    );
endinterface : dmc_link_if

// File: rtl/direct_memory_channel.sv
`timescale 1ns/10ps
module direct_memory_channel #(
    parameter int W = dmc_pkg::WORD_W,
    parameter int A = dmc_pkg::ADDR_W
) (
    input  wire logic         clk,           // 100 MHz clock
    input  wire logic         rst,           // Async reset, active high
    input  wire logic         start,         // Buffered record instruction pulse
    input  wire logic [1:0]   pkt_num,       // Record packet number
    input  wire logic         privileged,    // Instruction privileged
    input  wire logic [5:0]   dev_addr,      // Device address of instruction
    input  wire logic         cpu_mem_read,  // Processor has begun a read cycle
    input  wire logic         irq_unmasked,  // Channel 2 interrupt not masked
    input  wire logic         instr_end,     // End of processor instruction
    output logic              mem_req,       // Memory cycle request
    output logic              mem_we,        // Memory write
    output logic [A-1:0]      mem_addr,      // Memory address
    output logic [W-1:0]      mem_wdata,     // Memory write data
    input  wire logic [W-1:0] mem_rdata,     // Memory read data
    input  wire logic         mem_protect,   // Protect bit of addressed word
    input  wire logic         mem_done,      // Memory cycle complete
    output logic [A-1:0]      cur_addr,      // Current address, readable
    output logic              busy,          // Channel active
    output logic              done_irq,      // End of record pulse
    output logic              parity_irq,    // Input parity error pulse
    output logic              protect_irq,   // Protect violation pulse
    output logic              data_irq2,     // Data interrupt channel 2 level
    output logic [5:0]        ack_dev_addr,  // Acknowledging device address
    output logic              ack_valid,     // Acknowledge address valid pulse
    dmc_link_if.chan          link           // Link to device controllers
);
    // ****************************************
    // Registers
    // ****************************************
    dmc_pkg::dmc_state_t state_r;
    logic [A-1:0]   final_r;
    logic [A-1:0]   addr_r;
    logic [W-1:0]   data_r;
    logic [W-1:0]   func_r;
    logic [1:0]     pkt_idx_r;
    logic [1:0]     pkt_r;
    logic           priv_r;
    logic           dir_in_r;
    logic [5:0]     dev_r;
    logic           ack_pend_r;
    // Two-entry input buffer
    logic [W:0]     buf_r [2];
    logic [1:0]     cnt_r;
    logic           wp_r;
    logic           rp_r;
    logic           buf_full;
    logic           buf_empty;
    logic           pop;
    logic           steal_ok;

    assign buf_full  = (cnt_r == 2'h2);
    assign buf_empty = (cnt_r == 2'h0);
    assign steal_ok  = !cpu_mem_read;
    assign pop       = (state_r == dmc_pkg::ST_WAIT) && dir_in_r && !buf_empty && steal_ok;

    // ****************************************
    // Input buffer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 2'h0;
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
        end else begin
            if (link.from_dev_valid && link.from_dev_ready) begin
                buf_r[wp_r] <= {link.from_dev_par, link.from_dev_data};
                wp_r        <= ~wp_r;
            end
            if (pop)
                rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, link.from_dev_valid && link.from_dev_ready} - {1'b0, pop};
        end
    end
    assign link.from_dev_ready = busy && dir_in_r && !buf_full;

    // ****************************************
    // Transfer sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r     <= dmc_pkg::ST_IDLE;
            addr_r      <= '0;
            final_r     <= '0;
            data_r      <= '0;
            func_r      <= '0;
            pkt_idx_r   <= 2'h0;
            pkt_r       <= 2'h0;
            priv_r      <= 1'b0;
            dir_in_r    <= 1'b0;
            dev_r       <= 6'h00;
            done_irq    <= 1'b0;
            parity_irq  <= 1'b0;
            protect_irq <= 1'b0;
        end else begin
            done_irq    <= 1'b0;
            parity_irq  <= 1'b0;
            protect_irq <= 1'b0;
            case (state_r)
                dmc_pkg::ST_IDLE: begin
                    if (start) begin
                        pkt_r     <= pkt_num;
                        pkt_idx_r <= dmc_pkg::PKT_FUNC;
                        priv_r    <= privileged;
                        dev_r     <= dev_addr;
                        state_r   <= dmc_pkg::ST_PKT;
                    end
                end
                dmc_pkg::ST_PKT: begin
                    if (mem_done) begin
                        case (pkt_idx_r)
                            dmc_pkg::PKT_FUNC: begin
                                func_r   <= mem_rdata;
                                dir_in_r <= mem_rdata[dmc_pkg::FN_DIR_BIT];
                            end
                            dmc_pkg::PKT_FINAL: final_r <= mem_rdata[A-1:0];
                            default:            addr_r  <= mem_rdata[A-1:0];
                        endcase
                        if (pkt_idx_r == dmc_pkg::PKT_START)
                            state_r <= dmc_pkg::ST_WAIT;
                        pkt_idx_r <= pkt_idx_r + 2'h1;
                    end
                end
                dmc_pkg::ST_WAIT: begin
                    // Output direction only steals once the buffer can take a word
                    if (pop) begin
                        data_r  <= buf_r[rp_r][W-1:0];
                        state_r <= dmc_pkg::ST_STEAL;
                        if (!link.par_inhibit && (dmc_pkg::odd_parity(buf_r[rp_r][W-1:0]) != buf_r[rp_r][W]))
                            parity_irq <= 1'b1;
                    end else if (!dir_in_r && steal_ok && !link.to_dev_valid) begin
                        state_r <= dmc_pkg::ST_STEAL;
                    end
                end
                dmc_pkg::ST_STEAL: begin
                    // Processor stalls through mem_req, resumes after mem_done
                    if (mem_done) begin
                        if (!dir_in_r)
                            data_r <= mem_rdata;
                        else if (mem_protect && !priv_r && func_r[dmc_pkg::FN_PROTIRQ_BIT])
                            protect_irq <= 1'b1;
                        state_r <= dmc_pkg::ST_ADV;
                    end
                end
                default: begin
                    // Last output word must reach the device before the channel lets go of it
                    if (addr_r == final_r) begin
                        if (dir_in_r || !link.to_dev_valid) begin
                            done_irq <= 1'b1;
                            state_r  <= dmc_pkg::ST_IDLE;
                        end
                    end else begin
                        addr_r  <= addr_r + 1'b1;
                        state_r <= dmc_pkg::ST_WAIT;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Output word to device
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.to_dev_valid <= 1'b0;
            link.to_dev_data  <= '0;
            link.to_dev_par   <= 1'b0;
        end else if (state_r == dmc_pkg::ST_STEAL && mem_done && !dir_in_r) begin
            link.to_dev_valid <= 1'b1;
            link.to_dev_data  <= mem_rdata;
            link.to_dev_par   <= dmc_pkg::odd_parity(mem_rdata);
        end else if (link.to_dev_ready)
            link.to_dev_valid <= 1'b0;
    end

    // ****************************************
    // Memory port
    // ****************************************
    always_comb begin
        mem_req   = (state_r == dmc_pkg::ST_PKT) || (state_r == dmc_pkg::ST_STEAL);
        // Unprivileged store to protected word is suppressed; protect bit never driven
        mem_we    = (state_r == dmc_pkg::ST_STEAL) && dir_in_r && !(mem_protect && !priv_r);
        mem_addr  = (state_r == dmc_pkg::ST_PKT) ? (dmc_pkg::PKT_BASE + {11'h0, pkt_r, pkt_idx_r}) : addr_r;
        mem_wdata = data_r;
    end
    assign cur_addr = addr_r;
    assign busy     = (state_r != dmc_pkg::ST_IDLE);

    // ****************************************
    // Device interrupts on channel 2
    // ****************************************
    assign data_irq2 = link.dev_irq && !busy;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_pend_r   <= 1'b0;
            link.irq_ack <= 1'b0;
            ack_dev_addr <= 6'h00;
            ack_valid    <= 1'b0;
        end else begin
            ack_valid    <= 1'b0;
            // Two quiet cycles after each acknowledge let the answering device drop its request
            link.irq_ack <= data_irq2 && irq_unmasked && instr_end && !link.irq_ack && !ack_pend_r;
            ack_pend_r   <= link.irq_ack;
            if (link.irq_ack && link.ack_addr_valid) begin
                ack_dev_addr <= link.ack_addr;
                ack_valid    <= 1'b1;
            end
        end
    end

    assign link.func_word  = func_r;
    assign link.func_valid = (state_r == dmc_pkg::ST_PKT) && (pkt_idx_r == dmc_pkg::PKT_START) && mem_done;
    assign link.dev_sel    = dev_r;
    assign link.dir_in     = dir_in_r;
    assign link.active     = busy;
endmodule : direct_memory_channel

// File: rtl/dmc_device_port.sv
`timescale 1ns/10ps
module dmc_device_port #(
    parameter logic [5:0] DEV_ADDR = 6'h01   // This device's address
) (
    input  wire logic        clk,            // 100 MHz clock
    input  wire logic        rst,            // Async reset, active high
    input  wire logic [15:0] in_data,        // Word from peripheral
    input  wire logic        in_valid,       // Input word valid
    output logic             in_ready,       // Input word taken
    output logic [15:0]      out_data,       // Word to peripheral
    output logic             out_valid,      // Output word valid
    input  wire logic        out_ready,      // Peripheral takes output word
    output logic             out_par_err,    // Output parity error pulse
    input  wire logic        check_par,      // Check parity on output
    input  wire logic        want_irq,       // Device interrupt request
    input  wire logic        prior_pending,  // Nearer device has interrupt pending
    output logic             pass_pending,   // Pending passed to farther devices
    output logic [15:0]      func_word,      // Latched function word
    dmc_link_if.dev          link            // Link to channel
);
    logic selected;
    logic pend_r;

    assign selected = link.active && (link.dev_sel == DEV_ADDR);

    // ****************************************
    // Input path with parity
    // ****************************************
    assign link.from_dev_data  = in_data;
    assign link.from_dev_par   = dmc_pkg::odd_parity(in_data);
    assign link.from_dev_valid = selected && link.dir_in && in_valid;
    assign in_ready            = selected && link.dir_in && link.from_dev_ready;
    assign link.par_inhibit    = 1'b0;

    // ****************************************
    // Output path
    // ****************************************
    assign link.to_dev_ready = !out_valid || out_ready;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid   <= 1'b0;
            out_data    <= '0;
            out_par_err <= 1'b0;
            func_word   <= '0;
        end else begin
            out_par_err <= 1'b0;
            if (link.func_valid && link.dev_sel == DEV_ADDR)
                func_word <= link.func_word;
            if (selected && link.to_dev_valid && link.to_dev_ready) begin
                out_valid   <= 1'b1;
                out_data    <= link.to_dev_data;
                out_par_err <= check_par && (dmc_pkg::odd_parity(link.to_dev_data) != link.to_dev_par);
            end else if (out_ready)
                out_valid <= 1'b0;
        end
    end

    // ****************************************
    // Interrupt and acknowledge chain
    // ****************************************
    assign pass_pending        = prior_pending || pend_r;
    assign link.dev_irq        = pend_r || prior_pending;
    assign link.ack_addr       = DEV_ADDR;
    assign link.ack_addr_valid = link.irq_ack && pend_r && !prior_pending;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            pend_r <= 1'b0;
        else if (want_irq)
            pend_r <= 1'b1;
        else if (link.ack_addr_valid)
            pend_r <= 1'b0;
    end
endmodule : dmc_device_port

// File: testbench/dmc_link_monitor.sv
`timescale 1ns/10ps
module dmc_link_monitor (
    input wire logic        clk,          // Clock
    input wire logic        rst,          // Reset
    input wire logic        busy,         // Channel active
    input wire logic        privileged,   // Privileged transfer
    input wire logic        cpu_mem_read, // Processor read
    input wire logic        mem_req,      // Memory request
    input wire logic        mem_we,       // Memory write
    input wire logic        mem_protect,  // Protect bit
    input wire logic        mem_done,     // Memory done
    input wire logic [14:0] mem_addr,     // Memory address
    input wire logic        done_irq,     // End of record
    input wire logic        data_irq2,    // Channel 2 level
    input wire logic [15:0] to_dev_data,  // Output word
    input wire logic        to_dev_par,   // Output parity
    input wire logic        to_dev_valid, // Output valid
    input wire logic        to_dev_ready, // Output ready
    input wire logic        active,       // Link active
    input wire logic        dir_in        // Link direction
);
    // ****************************************
    // Channel and link properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_steal_no_read: assert property ($rose(mem_we) |-> !$past(cpu_mem_read))
        else $error("steal entered during processor read");
    a_protect_no_store: assert property (mem_req && mem_we && mem_protect |-> privileged)
        else $error("store to protected word");
    a_out_parity: assert property (to_dev_valid |-> to_dev_par == ~(^to_dev_data))
        else $error("bad output parity");
    a_out_word_hold: assert property (to_dev_valid && !to_dev_ready |=> to_dev_valid && $stable(to_dev_data))
        else $error("output word dropped or changed");
    a_irq_deferred: assert property (busy |-> !data_irq2)
        else $error("device interrupt while active");
    a_addr_stands: assert property (mem_req && !mem_done |=> mem_req && $stable(mem_addr))
        else $error("memory address not held");
    a_start_request: assert property ($rose(busy) |-> mem_req)
        else $error("no packet read after start");
    a_done_pulse: assert property (done_irq |-> !busy ##1 !done_irq)
        else $error("end of record not a pulse");
    a_dir_steady: assert property (active && !mem_req |=> $stable(dir_in))
        else $error("direction changed while active");
endmodule : dmc_link_monitor

// File: testbench/direct_memory_channel_tb.sv
`timescale 1ns/10ps
module direct_memory_channel_tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [5:0] DEV = 6'h05;
    logic clk, rst, start, privileged, cpu_mem_read, irq_unmasked, instr_end, want_irq;
    logic [1:0] pkt_num;
    logic [5:0] dev_addr, ack_dev_addr;
    logic mem_req, mem_we, mem_done, busy, done_irq, parity_irq, protect_irq, data_irq2, ack_valid;
    logic [14:0] mem_addr, cur_addr, wr_a;
    logic [15:0] mem_wdata, in_data, out_data, out_w, wr_d;
    logic in_valid, in_ready, out_valid, out_ready, out_par_err, in_hs, out_hs, mem_hs, wr_we;
    logic near_irq;
    logic [15:0] mem [0:32767];
    logic prot [0:32767];
    logic [15:0] in_q[$], got[$], exp_w[$];
    int n_fail, checks, n_done, n_prot, n_perr, cyc;
    dmc_link_if link ();
    direct_memory_channel u_direct_memory_channel (.clk, .rst, .start, .pkt_num, .privileged, .dev_addr,
        .cpu_mem_read, .irq_unmasked, .instr_end, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .mem_rdata(mem[mem_addr]), .mem_protect(prot[mem_addr]), .mem_done, .cur_addr, .busy, .done_irq,
        .parity_irq, .protect_irq, .data_irq2, .ack_dev_addr, .ack_valid, .link(link));
    dmc_device_port #(.DEV_ADDR(DEV)) u_dmc_device_port (.clk, .rst, .in_data, .in_valid, .in_ready,
        .out_data, .out_valid, .out_ready, .out_par_err, .check_par(1'b1), .want_irq, .prior_pending(near_irq),
        .pass_pending(), .func_word(), .link(link));
    dmc_link_monitor u_dmc_link_monitor (.clk, .rst, .busy, .privileged, .cpu_mem_read, .mem_req, .mem_we,
        .mem_protect(prot[mem_addr]), .mem_done, .mem_addr, .done_irq, .data_irq2,
        .to_dev_data(link.to_dev_data), .to_dev_par(link.to_dev_par), .to_dev_valid(link.to_dev_valid),
        .to_dev_ready(link.to_dev_ready), .active(link.active), .dir_in(link.dir_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ****************************************
    // Memory, peripheral and event counting
    // ****************************************
    always @(negedge clk) begin
        if (mem_hs && wr_we) mem[wr_a] = wr_d;
        if (in_hs) void'(in_q.pop_front());
        if (out_hs) got.push_back(out_w);
        if (done_irq === 1'b1) n_done++;
        if (protect_irq === 1'b1) n_prot++;
        if (parity_irq === 1'b1 || out_par_err === 1'b1) n_perr++;
        mem_done = mem_req && $urandom_range(2) != 0;
        mem_hs = mem_done;
        wr_we = mem_we;
        wr_a = mem_addr;
        wr_d = mem_wdata;
        if (in_hs || !in_valid) begin
            in_valid = in_q.size() != 0 && $urandom_range(2) != 0;
            in_data = in_valid ? in_q[0] : ~in_data;
        end
        in_hs = in_valid && in_ready;
        out_ready = $urandom_range(2) != 0;
        out_hs = out_valid && out_ready;
        out_w = out_data;
        cpu_mem_read = $urandom_range(3) == 0;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk

    function automatic logic [15:0] exp_word(input logic dir, input logic pr, input logic priv,
                                             input logic [15:0] old, input logic [15:0] w);
        exp_word = (!dir || (pr && !priv)) ? old : w;
    endfunction : exp_word

    // Acknowledge cycle with or without a nearer device holding a request
    task automatic ack_try(input logic near, input logic [15:0] exp_v);
        logic seen;
        seen = 1'b0;
        @(negedge clk);
        near_irq = near;
        irq_unmasked = 1'b1;
        instr_end = 1'b1;
        @(negedge clk) instr_end = 1'b0;
        for (int i = 0; i < 20 && !seen; i++) @(negedge clk) seen = (ack_valid === 1'b1);
        chk(16'(seen), exp_v, "acknowledge seen");
        if (exp_v[0]) chk(16'(ack_dev_addr), 16'(DEV), "acknowledging device");
        near_irq = 1'b0;
    endtask : ack_try

    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // One buffered record through a random packet; a second start is given while busy
    task automatic run(input logic dir, input logic priv, input int len);
        logic [14:0] s, f;
        logic [1:0] p;
        logic [15:0] w;
        int base, ep, t0;
        @(posedge clk);
        p = 2'($urandom_range(3));
        s = 15'h0100 + 15'($urandom_range(255));
        f = s + 15'(len - 1);
        base = int'(dmc_pkg::PKT_BASE) + 4 * int'(p);
        mem[base + int'(dmc_pkg::PKT_FUNC)] = {dir, 1'b1, 14'h0000};
        mem[base + int'(dmc_pkg::PKT_FINAL)] = {1'b0, f};
        mem[base + int'(dmc_pkg::PKT_START)] = {1'b0, s};
        exp_w = {};
        got = {};
        n_done = 0;
        n_prot = 0;
        ep = 0;
        for (int i = 0; i < len; i++) begin
            prot[s + 15'(i)] = 1'($urandom_range(1));
            w = 16'($urandom);
            if (dir) in_q.push_back(w);
            if (dir && prot[s + 15'(i)] && !priv) ep++;
            exp_w.push_back(exp_word(dir, prot[s + 15'(i)], priv, mem[s + 15'(i)], w));
        end
        @(negedge clk);
        start = 1'b1;
        pkt_num = p;
        privileged = priv;
        t0 = cyc;
        @(negedge clk) start = 1'b0;
        repeat (3) @(negedge clk);
        start = 1'b1;
        pkt_num = p + 2'h1;
        want_irq = 1'b1;
        @(negedge clk);
        start = 1'b0;
        want_irq = 1'b0;
        for (int i = 0; i < 3000 && (n_done == 0 || got.size() < (dir ? 0 : len)); i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #2;
        chk(16'(n_done), 16'h0001, "end of record count");
        chk(16'(cyc - t0 <= (len + 3) * dmc_pkg::MEM_CYCLE_CLKS), 16'h0001, "word rate");
        chk(16'(cur_addr), 16'(f), "current address");
        chk(16'(busy), 16'h0000, "channel still busy");
        chk(16'(n_prot), 16'(ep), "protect interrupts");
        chk(16'(in_q.size()), 16'h0000, "input words left");
        for (int i = 0; i < len; i++) chk(dir ? mem[s + 15'(i)] : got[i], exp_w[i], "record word");
        $display("run dir %0d priv %0d len %0d ends, n_fail %0d", dir, priv, len, n_fail);
    endtask : run

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hfa26));
        {rst, start, privileged, irq_unmasked, instr_end, want_irq} = 6'h20;
        {pkt_num, in_data, in_valid, out_ready, mem_done, cpu_mem_read} = '0;
        {in_hs, out_hs, mem_hs, wr_we} = 4'h0;
        dev_addr = DEV;
        near_irq = 1'b0;
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 16'($urandom);
            prot[i] = 1'b0;
        end
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        run(1'b0, 1'b0, 1);
        run(1'b1, 1'b0, 1);
        run(1'b1, 1'b1, 8);
        for (int i = 0; i < 24; i++) run(1'($urandom_range(1)), 1'($urandom_range(1)), $urandom_range(8, 1));
        #2;
        chk(16'(n_perr), 16'h0000, "parity errors");
        for (int i = 0; i < 20 && data_irq2 !== 1'b1; i++) @(negedge clk);
        chk(16'(data_irq2), 16'h0001, "deferred interrupt shown");
        ack_try(1'b1, 16'h0000);
        ack_try(1'b0, 16'h0001);
        $display("interrupt test ends, n_fail %0d", n_fail);
        wrap_up();
    end
endmodule : direct_memory_channel_tb
